// ===== core/pfs_pkg.sv
// Purpose: Constants for the program-flow and system-control executor.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes: Opcodes are 12 bits wide; cycle counts are whole core cycles.
package pfs_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_W = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FSR = 8'h0c;
    localparam logic [7:0] ADDR_MODE = 8'h10;
    localparam logic [7:0] ADDR_PC = 8'h14;
    localparam logic [7:0] ADDR_TOS = 8'h18;
    localparam logic [7:0] ADDR_SHADOW = 8'h1c;
    localparam logic [7:0] ADDR_SHADOW_PC = 8'h20;
    localparam logic [7:0] ADDR_RTC = 8'h24;
    localparam logic [7:0] ADDR_WATCHDOG = 8'h28;
    localparam logic [7:0] ADDR_CTRL = 8'h2c;
    localparam logic [7:0] ADDR_CORE = 8'h30;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ST_CARRY = 0;
    localparam int ST_ZERO = 2;
    localparam int ST_POWERDOWN = 3;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_PAGE_LO = 5;
    localparam int CTRL_PRESC_WD = 0;
    localparam int CTRL_WAKE = 1;
    // ------------------------------------------------------------
    // File register addresses
    // ------------------------------------------------------------
    localparam logic [4:0] FILE_RTC = 5'h01;
    localparam logic [4:0] FILE_PCL = 5'h02;
    localparam logic [4:0] FILE_STATUS = 5'h03;
    localparam logic [4:0] FILE_FSR = 5'h04;
    // ------------------------------------------------------------
    // Fixed opcodes
    // ------------------------------------------------------------
    localparam logic [11:0] OP_SLEEP = 12'h003;
    localparam logic [11:0] OP_RET = 12'h00c;
    localparam logic [11:0] OP_RET_PAGE = 12'h00d;
    localparam logic [11:0] OP_RET_INT = 12'h00e;
    localparam logic [11:0] OP_RET_INT_ADD = 12'h00f;
    localparam logic [11:0] OP_IMEM_READ = 12'h041;
    localparam logic [11:0] OP_MODE_TO_W = 12'h042;
    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam logic [2:0] CYC_ONE = 3'd1;
    localparam logic [2:0] CYC_SKIP = 3'd2;
    localparam logic [2:0] CYC_BRANCH = 3'd3;
    localparam logic [2:0] CYC_IMEM = 3'd4;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_STATUS = 8'h18;
    localparam logic [11:0] RST_PC = 12'hfff;
endpackage : pfs_pkg

// ===== core/pfs_core.sv
// Purpose: Executes program-control and system-control instructions.
// Assumes: Instructions arrive as APB writes to the instruction word.
// Notes: A busy or sleeping core stalls the next instruction write.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

module pfs_core
    import pfs_pkg::*;
#(
    parameter int STACK_DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [11:0] prog_addr,
    input wire logic [11:0] prog_data,
    output logic osc_stopped
);
    // Every assertion below runs on the core clock, off in reset
    default clocking cb_core @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] w_q, w_d; // Working register
    logic [7:0] status_q, status_d; // Page, flags
    logic [7:0] fsr_q, fsr_d; // File select register
    logic [3:0] mode_q, mode_d; // Mode register
    logic [11:0] pc_q, pc_d; // Program counter
    logic [7:0] rtc_q, rtc_d; // Real time counter
    logic [7:0] sh_w_q, sh_st_q, sh_fsr_q; // Shadow copies
    logic [3:0] sh_mode_q;
    logic [11:0] sh_pc_q;
    logic [7:0] wdog_q; // Watchdog count
    logic [7:0] presc_q; // Prescaler
    logic presc_wd_q; // Prescaler assigned to watchdog
    logic asleep_q; // Oscillator stopped
    logic [2:0] cnt_q; // Cycles left of current instruction
    logic [11:0] instr_q; // Last issued instruction
    logic imem_q; // Memory read in flight
    logic [11:0] stk_q [STACK_DEPTH]; // Return stack, entry 0 is top
    logic [3:0] sp_q; // Entries in use
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic [11:0] prog_addr_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic acc, wr, issue, stall, mapped;
    logic [11:0] op;
    assign acc = psel && penable && pready_q;
    assign wr = acc && pwrite && !pslverr_q;
    assign issue = wr && paddr == ADDR_INSTR;
    assign op = pwdata[11:0];
    // Instruction writes wait while busy or asleep
    assign stall = pwrite && paddr == ADDR_INSTR &&
                   (cnt_q != 3'd0 || asleep_q);
    assign mapped = paddr <= ADDR_CORE && paddr[1:0] == 2'b00;

    // File register read view
    function automatic logic [7:0] file_rd(input logic [4:0] f,
                                           input logic [7:0] rtc,
                                           input logic [11:0] pc,
                                           input logic [7:0] st,
                                           input logic [7:0] fs);
        logic [7:0] v;
        v = 8'h00;
        case (f)
            FILE_RTC: v = rtc;
            FILE_PCL: v = pc[7:0]; // Bit 0 is the PC lsb
            FILE_STATUS: v = st;
            FILE_FSR: v = fs;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : file_rd

    // ------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------
    logic push, pop, sleep_go, wake;
    logic [2:0] cyc;
    logic [7:0] fval, fnew, rel;
    logic fw;
    logic [4:0] ff;
    logic [11:0] tos;
    assign tos = stk_q[0];
    assign wake = wr && paddr == ADDR_CTRL && pwdata[CTRL_WAKE];
    assign ff = op[4:0];
    assign fval = file_rd(ff, rtc_q, pc_q, status_q, fsr_q);
    assign rel = pc_q[7:0] + 8'h01 + w_q;

    // Next state of the core registers
    always_comb begin
        w_d = w_q;
        status_d = status_q;
        fsr_d = fsr_q;
        mode_d = mode_q;
        pc_d = pc_q;
        rtc_d = rtc_q;
        push = 1'b0;
        pop = 1'b0;
        sleep_go = 1'b0;
        cyc = CYC_ONE;
        fw = 1'b0;
        fnew = 8'h00;
        if (imem_q && cnt_q == 3'd1) begin
            // Word lands in MODE:W at the last cycle
            {mode_d, w_d} = prog_data;
        end
        if (issue) begin
            pc_d = pc_q + 12'h001;
            if (op[11:8] == 4'h9) begin
                // Call
                push = 1'b1;
                pc_d = {status_q[7:5], 1'b0, op[7:0]};
                cyc = CYC_BRANCH;
            end else if (op[11:9] == 3'b101) begin
                // Jump, flags untouched
                pc_d = {status_q[7:5], op[8:0]};
                cyc = CYC_BRANCH;
            end else if (op[11:8] == 4'h8) begin
                // Literal return
                w_d = op[7:0];
                pop = 1'b1;
                pc_d = tos;
                cyc = CYC_BRANCH;
            end else if (op == OP_RET) begin
                // Page bits left alone
                pop = 1'b1;
                pc_d = tos;
                cyc = CYC_BRANCH;
            end else if (op == OP_RET_PAGE) begin
                // Page from stack entry
                pop = 1'b1;
                pc_d = tos;
                status_d[7:5] = tos[11:9];
                cyc = CYC_BRANCH;
            end else if (op == OP_RET_INT || op == OP_RET_INT_ADD) begin
                // Shadow restore, timeout and powerdown kept
                w_d = sh_w_q;
                status_d = {sh_st_q[7:5], status_q[4:3], sh_st_q[2:0]};
                fsr_d = sh_fsr_q;
                mode_d = sh_mode_q;
                pc_d = sh_pc_q;
                cyc = CYC_BRANCH;
                if (op[0]) begin
                    // Counter gets the pre-restore W
                    rtc_d = rtc_q + w_q;
                end
            end else if (op[11:3] == 9'b0_0000_0011) begin
                fsr_d[6:4] = op[2:0]; // Bank select
            end else if (op[11:3] == 9'b0_0000_0010) begin
                status_d[7:5] = op[2:0]; // Page select
            end else if (op == OP_IMEM_READ) begin
                cyc = CYC_IMEM; // Four cycles
            end else if (op == OP_MODE_TO_W) begin
                w_d = {4'h0, mode_q}; // Upper nibble cleared
            end else if (op == OP_SLEEP) begin
                // Timeout set, powerdown cleared
                sleep_go = 1'b1;
                status_d[ST_TIMEOUT] = 1'b1;
                status_d[ST_POWERDOWN] = 1'b0;
            end else if (op[11:5] == 7'b000_0001) begin
                fw = 1'b1;
                fnew = w_q;
            end else if (op[11:5] == 7'b000_1111 && ff == FILE_PCL) begin
                // Relative jump from the next word
                pc_d = {status_q[7:5], 1'b0, rel};
                cyc = CYC_BRANCH;
            end else if (op[11:9] == 3'b010) begin
                // Bit clear or set; carry and zero sit here
                fw = 1'b1;
                fnew = fval;
                fnew[op[7:5]] = op[8];
            end else if (op[11:9] == 3'b011) begin
                // Skip discards the next word, two cycles
                if (fval[op[7:5]] == op[8]) begin
                    pc_d = pc_q + 12'h002;
                    cyc = CYC_SKIP;
                end
            end
            if (fw) begin
                case (ff)
                    FILE_RTC: rtc_d = fnew;
                    FILE_PCL: begin
                        // Absolute indirect jump
                        pc_d = {status_q[7:5], 1'b0, fnew};
                        cyc = CYC_BRANCH;
                    end
                    FILE_STATUS: begin
                        status_d = {fnew[7:5], status_q[4:3], fnew[2:0]};
                    end
                    FILE_FSR: fsr_d = fnew;
                    default: fnew = 8'h00;
                endcase
            end
        end
        // Software access to the visible registers
        if (wr) begin
            case (paddr)
                ADDR_W: w_d = pwdata[7:0];
                ADDR_STATUS: status_d = pwdata[7:0];
                ADDR_FSR: fsr_d = pwdata[7:0];
                ADDR_MODE: mode_d = pwdata[3:0];
                ADDR_PC: pc_d = pwdata[11:0];
                ADDR_RTC: rtc_d = pwdata[7:0];
                default: rtc_d = rtc_d;
            endcase
        end
    end

    // Core register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_q <= 8'h00;
            status_q <= RST_STATUS;
            fsr_q <= 8'h00;
            mode_q <= 4'h0;
            pc_q <= RST_PC;
            rtc_q <= 8'h00;
        end else begin
            w_q <= w_d;
            status_q <= status_d;
            fsr_q <= fsr_d;
            mode_q <= mode_d;
            pc_q <= pc_d;
            rtc_q <= rtc_d;
        end
    end

    // Shadow copies, loaded by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sh_mode_q, sh_fsr_q, sh_st_q, sh_w_q} <= 28'h000_0000;
            sh_pc_q <= 12'h000;
        end else if (wr && paddr == ADDR_SHADOW) begin
            {sh_mode_q, sh_fsr_q, sh_st_q, sh_w_q} <= pwdata[27:0];
        end else if (wr && paddr == ADDR_SHADOW_PC) begin
            sh_pc_q <= pwdata[11:0];
        end
    end

    // Cycle counter holds off the next instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 3'd0;
            instr_q <= 12'h000;
            imem_q <= 1'b0;
            prog_addr_q <= 12'h000;
        end else if (issue) begin
            cnt_q <= cyc - 3'd1;
            instr_q <= op;
            imem_q <= op == OP_IMEM_READ;
            prog_addr_q <= {mode_q, w_q}; // Address MODE:W
        end else if (cnt_q != 3'd0) begin
            cnt_q <= cnt_q - 3'd1;
            imem_q <= imem_q && cnt_q != 3'd1;
        end
    end

    // Watchdog, prescaler and oscillator stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_q <= 8'h00;
            presc_q <= 8'h00;
            presc_wd_q <= 1'b0;
            asleep_q <= 1'b0;
        end else begin
            if (wr && paddr == ADDR_CTRL) begin
                presc_wd_q <= pwdata[CTRL_PRESC_WD];
            end
            if (sleep_go) begin
                wdog_q <= 8'h00;
                asleep_q <= 1'b1;
                if (presc_wd_q) begin
                    presc_q <= 8'h00;
                end
            end else if (asleep_q) begin
                // Clock stopped: counts frozen until woken
                asleep_q <= !wake;
            end else begin
                presc_q <= presc_q + 8'h01;
                if (!presc_wd_q || presc_q == 8'hff) begin
                    wdog_q <= wdog_q + 8'h01;
                end
            end
        end
    end

    // Return stack, one shift stage per entry
    generate
        for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stk
            logic [11:0] push_src, pop_src; // Neighbour values
            // Split per end so no entry indexes past the array
            if (i == 0) begin : g_top
                assign push_src = pc_q + 12'h001;
            end else begin : g_below
                assign push_src = stk_q[i-1];
            end
            if (i == STACK_DEPTH - 1) begin : g_last
                assign pop_src = 12'h000; // Empty slot enters on pop
            end else begin : g_above
                assign pop_src = stk_q[i+1];
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stk_q[i] <= 12'h000;
                end else if (push) begin
                    // Oldest entry falls off the bottom
                    stk_q[i] <= push_src;
                end else if (pop) begin
                    stk_q[i] <= pop_src;
                end
            end
        end
    endgenerate

    // Stack occupancy, saturating both ways
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= 4'h0;
        end else if (push && sp_q != 4'(STACK_DEPTH)) begin
            sp_q <= sp_q + 4'h1;
        end else if (pop && sp_q != 4'h0) begin
            sp_q <= sp_q - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // APB slave, one wait state, more while stalled
    // ------------------------------------------------------------
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        case (paddr)
            ADDR_INSTR: rd_val = {20'h0_0000, instr_q};
            ADDR_W: rd_val = {24'h00_0000, w_q};
            ADDR_STATUS: rd_val = {24'h00_0000, status_q};
            ADDR_FSR: rd_val = {24'h00_0000, fsr_q};
            ADDR_MODE: rd_val = {28'h000_0000, mode_q};
            ADDR_PC: rd_val = {20'h0_0000, pc_q};
            ADDR_TOS: rd_val = {20'h0_0000, tos};
            ADDR_SHADOW: rd_val = {4'h0, sh_mode_q, sh_fsr_q, sh_st_q,
                                   sh_w_q};
            ADDR_SHADOW_PC: rd_val = {20'h0_0000, sh_pc_q};
            ADDR_RTC: rd_val = {24'h00_0000, rtc_q};
            ADDR_WATCHDOG: rd_val = {16'h0000, presc_q, wdog_q};
            ADDR_CTRL: rd_val = {31'h0000_0000, presc_wd_q};
            ADDR_CORE: rd_val = {24'h00_0000, sp_q, 2'b00, asleep_q,
                                 cnt_q != 3'd0};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Handshake and read capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && penable && !pready_q && !stall;
            pslverr_q <= psel && penable && !pready_q && !stall && !mapped;
            prdata_q <= (psel && !pwrite) ? rd_val : 32'h0000_0000;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prog_addr = prog_addr_q;
    assign osc_stopped = asleep_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_three;
        cnt_q == 3'd2 ##1 cnt_q == 3'd1 ##1 cnt_q == 3'd0;
    endsequence
    sequence s_four;
        cnt_q == 3'd3 ##1 cnt_q == 3'd2 ##1 cnt_q == 3'd1 ##1 cnt_q == 3'd0;
    endsequence

    a_call_target: assert property (
        issue && op[11:8] == 4'h9 |=> pc_q == {$past(status_q[7:5]), 1'b0,
        $past(pwdata[7:0])} && stk_q[0] == $past(pc_q) + 12'h001 ##0 s_three)
        else $error("call target or stack wrong");
    a_jump_target: assert property (
        issue && op[11:9] == 3'b101 |=> pc_q == {$past(status_q[7:5]),
        $past(pwdata[8:0])} && status_q == $past(status_q))
        else $error("jump target wrong");
    a_page_return: assert property (
        issue && op == OP_RET_PAGE |=> status_q[7:5] == $past(stk_q[0][11:9])
        && pc_q == $past(stk_q[0]))
        else $error("page return wrong");
    a_int_keep_flags: assert property (
        issue && op == OP_RET_INT |=> status_q[4:3] == $past(status_q[4:3])
        && pc_q == $past(sh_pc_q) && w_q == $past(sh_w_q))
        else $error("interrupt return restore wrong");
    a_counter_add: assert property (
        issue && op == OP_RET_INT_ADD |=> rtc_q == $past(rtc_q) + $past(w_q))
        else $error("counter not adjusted");
    a_bank_select: assert property (
        issue && op[11:3] == 9'b0_0000_0011 |=> fsr_q[6:4] == $past(op[2:0])
        && cnt_q == 3'd0)
        else $error("bank select wrong");
    a_imem_length: assert property (
        issue && op == OP_IMEM_READ |=> s_four ##0 {mode_q, w_q} ==
        $past(prog_data))
        else $error("memory read timing wrong");
    a_sleep_flags: assert property (
        issue && op == OP_SLEEP |=> wdog_q == 8'h00 && status_q[4] &&
        !status_q[3] && osc_stopped)
        else $error("sleep entry wrong");
    a_mode_to_w: assert property (
        issue && op == OP_MODE_TO_W |=> w_q == {4'h0, $past(mode_q)})
        else $error("mode copy wrong");
    a_busy_stall: assert property (
        cnt_q != 3'd0 |-> !issue)
        else $error("instruction issued while busy");
    a_rel_jump: assert property (
        issue && op[11:5] == 7'b000_1111 && op[4:0] == FILE_PCL |=>
        pc_q == {$past(status_q[7:5]), 1'b0,
        8'($past(pc_q[7:0]) + $past(w_q) + 8'h01)} ##0 s_three)
        else $error("relative jump wrong");
    a_skip_taken: assert property (
        issue && op[11:9] == 3'b011 && fval[op[7:5]] == op[8] |=>
        pc_q == $past(pc_q) + 12'h002 ##0 cnt_q == 3'd1 ##1 cnt_q == 3'd0)
        else $error("taken skip wrong");
endmodule : pfs_core

// ===== testbench/pfs_prog_mem.sv
// Purpose: Program memory seen by the executor's memory-read port.
// Assumes: Synchronous read; the word follows the address by one edge.
// Notes: Contents are address xor a mask, so the bench can predict them.
`timescale 1ns/1ps
module pfs_prog_mem (
    input wire logic pclk,
    input wire logic [11:0] prog_addr,
    output logic [11:0] prog_data = 12'h000
);
    // --------------------------------------------------------------
    // Read port
    // --------------------------------------------------------------
    // Registered, so a new address shows its word one edge later, with the stale word until then
    always @(posedge pclk) begin
        prog_data <= prog_addr ^ 12'h5a5;
    end
endmodule : pfs_prog_mem

// ===== testbench/test_program_flow_system_ops.sv
// Purpose: Self-checking bench for the flow and system executor.
// Assumes: APB master; instruction stalls end when pready rises.
// Notes: Table rows share core state, so their order matters.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_program_flow_system_ops
    import pfs_pkg::*;
;
    // Instruction, then two register reads with expected values
    typedef struct {
        logic [11:0] op;
        logic [7:0] a1;
        logic [11:0] e1;
        logic [7:0] a2;
        logic [11:0] e2;
    } pfs_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic osc_stopped;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [11:0] prog_addr, prog_data;
    int err_count = 0;
    int tests_run = 0;
    pfs_row_t rows [11] = '{
        '{12'h013, ADDR_STATUS, 12'h078, ADDR_PC, 12'h000},
        '{12'h01d, ADDR_FSR, 12'h050, ADDR_STATUS, 12'h078},
        '{12'hbab, ADDR_PC, 12'h7ab, ADDR_STATUS, 12'h078},
        '{12'h942, ADDR_PC, 12'h642, ADDR_TOS, 12'h7ac},
        '{12'h011, ADDR_STATUS, 12'h038, ADDR_TOS, 12'h7ac},
        '{12'h00c, ADDR_PC, 12'h7ac, ADDR_STATUS, 12'h038},
        '{12'h910, ADDR_PC, 12'h210, ADDR_TOS, 12'h7ad},
        '{12'h00d, ADDR_PC, 12'h7ad, ADDR_STATUS, 12'h078},
        '{12'h920, ADDR_PC, 12'h620, ADDR_TOS, 12'h7ae},
        '{12'h85a, ADDR_PC, 12'h7ae, ADDR_W, 12'h05a},
        '{12'h022, ADDR_PC, 12'h65a, ADDR_W, 12'h05a}
    };
    pfs_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prog_addr(prog_addr),
        .prog_data(prog_data), .osc_stopped(osc_stopped));
    pfs_prog_mem u_mem (.pclk(pclk), .prog_addr(prog_addr),
        .prog_data(prog_data));
    // --------------------------------------------------------------
    // Clock and bus tasks
    // --------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Verdict and counts; every hang ends here as well
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    // One APB transfer; held until pready, then an idle edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 300);
        if (n >= 300) begin
            err_count++;
            results();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    // Issue, then poll the busy bit so results are final
    task automatic issue(input logic [11:0] op);
        int k;
        k = 0;
        xfer(1'b1, ADDR_INSTR, {20'h0, op});
        do begin
            xfer(1'b0, ADDR_CORE, 32'h0);
            k++;
        end while (rdat[0] !== 1'b0 && k < 20);
        if (k >= 20) begin
            err_count++;
            results();
        end
    endtask : issue
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rdat)
    endtask : rchk
    // Preset status and program counter, then one bit-test skip or relative jump
    task automatic skipt(input logic [7:0] st, input logic [11:0] pc,
                         input logic [11:0] op, input logic [11:0] e);
        xfer(1'b1, ADDR_STATUS, {24'h0, st});
        xfer(1'b1, ADDR_PC, {20'h0, pc});
        issue(op);
        rchk(ADDR_PC, {20'h0, e});
    endtask : skipt
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            issue(rows[i].op);
            rchk(rows[i].a1, {20'h0, rows[i].e1});
            rchk(rows[i].a2, {20'h0, rows[i].e2});
        end
        $display("test table done");
        skipt(8'h18, 12'h100, 12'h602, 12'h102);
        skipt(8'h18, 12'h101, 12'h602, 12'h102);
        skipt(8'h19, 12'h100, 12'h603, 12'h101);
        skipt(8'h18, 12'h100, 12'h643, 12'h102);
        skipt(8'h38, 12'h110, 12'h1e2, 12'h26b);
        // Clear-carry and clear-zero aliases on the status file
        xfer(1'b1, ADDR_STATUS, 32'h1d);
        issue(12'h403);
        rchk(ADDR_STATUS, 32'h1c);
        issue(12'h443);
        rchk(ADDR_STATUS, 32'h18);
        $display("test skips done");
        xfer(1'b1, ADDR_MODE, 32'h3);
        xfer(1'b1, ADDR_W, 32'h21);
        issue(OP_IMEM_READ);
        `CHK("prog_addr", 12'h321, prog_addr)
        rchk(ADDR_MODE, 32'h6);
        rchk(ADDR_W, 32'h84);
        issue(OP_MODE_TO_W);
        rchk(ADDR_W, 32'h6);
        // Back to back: the second write must wait out the read
        xfer(1'b1, ADDR_INSTR, {20'h0, OP_IMEM_READ});
        issue(OP_MODE_TO_W);
        rchk(ADDR_MODE, 32'h3);
        rchk(ADDR_W, 32'h3);
        $display("test memory read done");
        // Counter-adjust return first, then plain interrupt return
        for (int j = 0; j < 2; j++) begin
            xfer(1'b1, ADDR_STATUS, j ? 32'h08 : 32'h18);
            xfer(1'b1, ADDR_W, 32'h40);
            xfer(1'b1, ADDR_RTC, 32'h10);
            xfer(1'b1, ADDR_SHADOW, 32'h0633_e511);
            xfer(1'b1, ADDR_SHADOW_PC, 32'h123);
            issue(j ? OP_RET_INT : OP_RET_INT_ADD);
            rchk(ADDR_STATUS, j ? 32'hed : 32'hfd);
            rchk(ADDR_PC, 32'h123);
            rchk(ADDR_FSR, 32'h33);
            rchk(ADDR_MODE, 32'h6);
            rchk(ADDR_W, 32'h11);
            rchk(ADDR_RTC, j ? 32'h10 : 32'h50);
        end
        $display("test interrupt returns done");
        xfer(1'b1, ADDR_CTRL, 32'h1);
        issue(OP_SLEEP);
        `CHK("osc_stopped", 1'b1, osc_stopped)
        xfer(1'b0, ADDR_STATUS, 32'h0);
        `CHK("sleep flags", 2'b10, rdat[4:3])
        rchk(ADDR_WATCHDOG, 32'h0);
        xfer(1'b1, ADDR_CTRL, 32'h2);
        `CHK("woken", 1'b0, osc_stopped)
        xfer(1'b0, 8'h34, 32'h0);
        `CHK("unmapped err", 1'b1, rerr)
        `CHK("unmapped data", 32'h0, rdat)
        $display("test sleep and unmapped done");
        // Mid-run reset must bring back the documented start state
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        `CHK("reset pready", 1'b0, pready)
        `CHK("reset prog_addr", 12'h000, prog_addr)
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(ADDR_STATUS, 32'h18);
        rchk(ADDR_PC, 32'hfff);
        $display("test reset done");
        results();
    end
endmodule : test_program_flow_system_ops
